/* File: hdl/bin_framer_regs.svh */
// Constants for the binary measurement output framer.
// Assumes inclusion by bare name from the hdl/ folder.
`ifndef BIN_FRAMER_REGS_SVH
`define BIN_FRAMER_REGS_SVH

// ==========================================================
// Header characters
`define BF_HDR_MARK 8'h23
`define BF_HDR_LEN_DIGIT 8'h36
`define BF_ASCII_ZERO 8'h30
`define BF_HDR_LAST_POS 20'h00007

// ==========================================================
// Sample and block sizes
`define BF_SAMPLE_BYTES 20'h0000A
`define BF_SAMPLE_LAST_IDX 4'h9
`define BF_MAX_BLOCK 17'h1869E
`define BF_FORMAT_COUNT 5'h14
`define BF_LAST_DIGIT_IDX 3'h5

// ==========================================================
// Interpolator/status field bit positions
`define BF_ST_INHIBIT 4'h5
`define BF_ST_BLOCK_START 4'h6
`define BF_ST_TOTAL1 4'h7
`define BF_ST_TOTAL2 4'h8

`endif

/* File: hdl/bin_framer_pkg.sv */
// Types shared by the binary measurement output framer.
// Assumes nothing of its surroundings.
package bin_framer_pkg;

    // ==========================================================
    // Configuration
    typedef enum logic [3:0] {
        FUNC_FREQ = 4'h0,
        FUNC_PERIOD = 4'h1,
        FUNC_TIME_INTERVAL = 4'h2,
        FUNC_PHASE = 4'h3,
        FUNC_TOTALIZE = 4'h4,
        FUNC_HISTOGRAM = 4'h5,
        FUNC_PEAK_AMPLITUDE = 4'h6
    } meas_func_t;

    typedef enum logic [1:0] {
        ARM_AUTO = 2'h0,
        ARM_EDGE = 2'h1,
        ARM_INTERVAL = 2'h2,
        ARM_EXTERNAL = 2'h3
    } arm_mode_t;

    typedef struct packed {
        meas_func_t func;
        arm_mode_t arm;
        logic extra_data;
    } meas_cfg_t;

    // ==========================================================
    // One captured sample
    typedef struct packed {
        logic [31:0] event_count;
        logic [31:0] time_count;
        logic [4:0] interp;
        logic inhibit;
        logic totalize_flag_one;
        logic totalize_flag_two;
    } sample_t;

    // ==========================================================
    // Framer state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CALC = 2'b01,
        ST_HDR = 2'b11,
        ST_DATA = 2'b10
    } frame_state_t;

    typedef struct packed {
        frame_state_t st;
        logic [19:0] rem;
        logic [2:0] dig_idx;
        logic [5:0][3:0] digits;
        logic [16:0] total;
        logic [16:0] left;
        logic [16:0] taken;
        logic [3:0] sidx;
        logic [79:0] sh;
        logic first;
        logic [19:0] pos;
        logic [7:0] byte_r;
        logic valid;
        logic last;
        logic reject;
        logic [4:0] fmt;
    } framer_state_t;

endpackage : bin_framer_pkg

/* File: hdl/measurement_binary_output_framer.sv */
// Binary output framer: ASCII length header, then samples as bytes.
// Assumes samples and configuration come from logic on clk_i and a
// byte sink with valid/ready on the same clock.
//
// Summary of operation
// [RULE1] Histogram and peak amplitude requests are refused, never framed.
// [RULE2] The controller sends no queries while binary mode is on.
// [RULE3] One of 20 layouts is picked from function, arming and extra data.
// [RULE4] A frame is an ASCII header and then only binary data.
// [RULE5] Output is 8-bit bytes, most significant byte first.
// [RULE6] The header is '#', '6' and six decimal digits of payload length.
// [RULE7] A block of N results carries the N+1 samples needed to derive them.
// [RULE8] The controller selects binary mode before it asks for data.
// [RULE9] A sample is event count, time count, status field, each MSB first.
// [RULE10] Status holds interpolator bits, inhibit at bit 5, block start at 6.
// [RULE11] The header length digits are zero padded on the left.
`timescale 1ns/1ns
`default_nettype none
`include "bin_framer_regs.svh"

module measurement_binary_output_framer (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic binary_mode_i,
    input wire logic start_i,
    input wire bin_framer_pkg::meas_cfg_t cfg_i,
    input wire logic [16:0] block_len_i,
    input wire logic sample_valid_i,
    input wire bin_framer_pkg::sample_t sample_i,
    output logic sample_ready_o,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic byte_last_o,
    input wire logic byte_ready_i,
    output logic busy_o,
    output logic reject_o,
    output logic [4:0] format_o
);

    // ==========================================================
    // Helpers
    function automatic logic unsupported(input bin_framer_pkg::meas_func_t f);
        return (f == bin_framer_pkg::FUNC_HISTOGRAM) ||
               (f == bin_framer_pkg::FUNC_PEAK_AMPLITUDE) ||
               (f > bin_framer_pkg::FUNC_PEAK_AMPLITUDE);
    endfunction : unsupported

    function automatic logic [4:0] fmt_of(input bin_framer_pkg::meas_cfg_t c);
        logic trig;
        trig = (c.arm != bin_framer_pkg::ARM_AUTO);
        return {c.func[2:0], 2'h0} + {3'h0, trig, c.extra_data};
    endfunction : fmt_of

    function automatic logic [19:0] pow10(input logic [2:0] i);
        case (i)
            3'h0: return 20'h186A0;
            3'h1: return 20'h02710;
            3'h2: return 20'h003E8;
            3'h3: return 20'h00064;
            3'h4: return 20'h0000A;
            default: return 20'h00001;
        endcase
    endfunction : pow10

    function automatic logic [19:0] dec_value(input logic [5:0][3:0] d);
        logic [19:0] v;
        v = 20'h0;
        for (int i = 0; i < 6; i++) begin
            v = v + 20'(d[i] * pow10(3'(i)));
        end
        return v;
    endfunction : dec_value

    function automatic logic [79:0] pack(input bin_framer_pkg::sample_t p,
                                         input logic first);
        logic [15:0] status;
        status = 16'h0000;
        status[4:0] = p.interp;
        status[`BF_ST_INHIBIT] = p.inhibit;
        status[`BF_ST_BLOCK_START] = first;
        status[`BF_ST_TOTAL1] = p.totalize_flag_one;
        status[`BF_ST_TOTAL2] = p.totalize_flag_two;
        return {p.event_count, p.time_count, status};
    endfunction : pack

    // ==========================================================
    // State
    bin_framer_pkg::framer_state_t s_r;
    bin_framer_pkg::framer_state_t s_nxt;
    logic free;
    logic take;
    logic [16:0] n_plus1;
    logic [79:0] packed_in;

    assign free = !s_r.valid || byte_ready_i;
    assign sample_ready_o = (s_r.st == bin_framer_pkg::ST_DATA) && free &&
                            (s_r.sidx == 4'h0) && (s_r.left != 17'h0);
    assign take = sample_ready_o && sample_valid_i;
    assign n_plus1 = 17'(block_len_i + 17'h1);
    assign packed_in = pack(sample_i, s_r.first);

    always_comb begin
        s_nxt = s_r;
        s_nxt.reject = 1'b0;
        if (free) begin
            s_nxt.valid = 1'b0;
            s_nxt.last = 1'b0;
        end
        case (s_r.st)
            bin_framer_pkg::ST_IDLE: begin
                // Start is honoured only once binary mode is selected [RULE8]
                if (start_i && binary_mode_i) begin
                    if (unsupported(cfg_i.func) || block_len_i == 17'h0 ||
                        block_len_i > `BF_MAX_BLOCK) begin
                        s_nxt.reject = 1'b1; // [RULE1]
                    end else begin
                        s_nxt.st = bin_framer_pkg::ST_CALC;
                        s_nxt.fmt = fmt_of(cfg_i); // [RULE3]
                        s_nxt.total = n_plus1; // [RULE7]
                        s_nxt.left = n_plus1;
                        s_nxt.taken = 17'h0;
                        s_nxt.rem = 20'({3'h0, n_plus1} * `BF_SAMPLE_BYTES);
                        s_nxt.dig_idx = 3'h0;
                        s_nxt.digits = '0; // [RULE11]
                        s_nxt.pos = 20'h0;
                        s_nxt.sidx = 4'h0;
                        s_nxt.first = 1'b1;
                    end
                end
            end
            bin_framer_pkg::ST_CALC: begin
                // Repeated subtraction: slow but tiny, runs once per frame
                if (s_r.rem >= pow10(s_r.dig_idx)) begin
                    s_nxt.rem = s_r.rem - pow10(s_r.dig_idx);
                    s_nxt.digits[s_r.dig_idx] = s_r.digits[s_r.dig_idx] + 4'h1;
                end else if (s_r.dig_idx == `BF_LAST_DIGIT_IDX) begin
                    s_nxt.st = bin_framer_pkg::ST_HDR;
                end else begin
                    s_nxt.dig_idx = s_r.dig_idx + 3'h1;
                end
            end
            bin_framer_pkg::ST_HDR: begin
                if (free) begin
                    s_nxt.valid = 1'b1;
                    case (s_r.pos[2:0]) // [RULE6]
                        3'h0: s_nxt.byte_r = `BF_HDR_MARK;
                        3'h1: s_nxt.byte_r = `BF_HDR_LEN_DIGIT;
                        default: s_nxt.byte_r = `BF_ASCII_ZERO +
                            {4'h0, s_r.digits[3'(s_r.pos[2:0] - 3'h2)]};
                    endcase
                    s_nxt.pos = s_r.pos + 20'h1;
                    if (s_r.pos == `BF_HDR_LAST_POS) begin
                        s_nxt.st = bin_framer_pkg::ST_DATA; // [RULE4]
                    end
                end
            end
            bin_framer_pkg::ST_DATA: begin
                if (free) begin
                    if (s_r.sidx == 4'h0) begin
                        if (s_r.left == 17'h0) begin
                            s_nxt.st = bin_framer_pkg::ST_IDLE;
                        end else if (take) begin
                            s_nxt.valid = 1'b1;
                            s_nxt.byte_r = packed_in[79:72]; // [RULE9]
                            s_nxt.sh = {packed_in[71:0], 8'h00}; // [RULE10]
                            s_nxt.sidx = 4'h1;
                            s_nxt.first = 1'b0;
                            s_nxt.taken = s_r.taken + 17'h1;
                            s_nxt.pos = s_r.pos + 20'h1;
                        end
                    end else begin
                        s_nxt.valid = 1'b1;
                        s_nxt.byte_r = s_r.sh[79:72]; // [RULE5]
                        s_nxt.sh = {s_r.sh[71:0], 8'h00};
                        s_nxt.pos = s_r.pos + 20'h1;
                        if (s_r.sidx == `BF_SAMPLE_LAST_IDX) begin
                            s_nxt.sidx = 4'h0;
                            s_nxt.left = s_r.left - 17'h1;
                            s_nxt.last = (s_r.left == 17'h1);
                        end else begin
                            s_nxt.sidx = s_r.sidx + 4'h1;
                        end
                    end
                end
            end
            default: s_nxt = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign byte_valid_o = s_r.valid;
    assign byte_o = s_r.byte_r;
    assign byte_last_o = s_r.last;
    assign busy_o = (s_r.st != bin_framer_pkg::ST_IDLE);
    assign reject_o = s_r.reject;
    assign format_o = s_r.fmt;

    // ==========================================================
    // Checks
    logic fire;
    logic in_hdr;
    assign fire = byte_valid_o && byte_ready_i;
    assign in_hdr = (s_r.st == bin_framer_pkg::ST_HDR);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_no_hist;
        !busy_o && start_i && binary_mode_i && unsupported(cfg_i.func)
            |=> reject_o && !busy_o;
    endproperty
    a_no_hist: assert property (p_no_hist) else $error("unsupported function framed"); // [RULE1]

    property p_fmt;
        !busy_o && start_i && binary_mode_i && !unsupported(cfg_i.func)
            && block_len_i != 17'h0 && block_len_i <= `BF_MAX_BLOCK
            |=> busy_o && format_o == fmt_of($past(cfg_i)) && format_o < `BF_FORMAT_COUNT;
    endproperty
    a_fmt: assert property (p_fmt) else $error("format index wrong"); // [RULE3]

    property p_bin_after_hdr;
        fire && s_r.pos > `BF_HDR_LAST_POS + 20'h1 |-> !in_hdr;
    endproperty
    a_bin_after_hdr: assert property (p_bin_after_hdr) else $error("header after data"); // [RULE4]

    property p_hold;
        byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o);
    endproperty
    a_hold: assert property (p_hold) else $error("byte dropped while stalled"); // [RULE5]

    property p_hdr_chars;
        fire && (s_r.pos == 20'h1 || s_r.pos == 20'h2) |->
            byte_o == ((s_r.pos == 20'h1) ? `BF_HDR_MARK : `BF_HDR_LEN_DIGIT);
    endproperty
    a_hdr_chars: assert property (p_hdr_chars) else $error("header lead wrong"); // [RULE6]

    property p_hdr_digits;
        fire && s_r.pos > 20'h2 && s_r.pos <= 20'h8 |->
            byte_o >= `BF_ASCII_ZERO && byte_o <= `BF_ASCII_ZERO + 8'h09;
    endproperty
    a_hdr_digits: assert property (p_hdr_digits) else $error("header digit not ASCII"); // [RULE6]

    property p_count;
        $fell(busy_o) |-> s_r.taken == s_r.total;
    endproperty
    a_count: assert property (p_count) else $error("sample count short"); // [RULE7]

    property p_msb_first;
        take |=> byte_valid_o && byte_o == $past(sample_i.event_count[31:24]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("event MSB not first"); // [RULE9]

    property p_status;
        take |=> s_r.sh[8 + 6] == $past(s_r.first) &&
                 s_r.sh[8 + 5] == $past(sample_i.inhibit) &&
                 s_r.sh[12:8] == $past(sample_i.interp);
    endproperty
    a_status: assert property (p_status) else $error("status field wrong"); // [RULE10]

    property p_pad;
        $rose(in_hdr) |-> dec_value(s_r.digits) == 20'({3'h0, s_r.total} * `BF_SAMPLE_BYTES);
    endproperty
    a_pad: assert property (p_pad) else $error("header length wrong"); // [RULE11]

endmodule : measurement_binary_output_framer
`default_nettype wire

/* File: verif/byte_sink_model.sv */
// Byte sink standing in for the bus controller that reads the frame.
// Assumes bytes are offered on clk_i with a valid/ready handshake.
`timescale 1ns/1ns
`default_nettype none

module byte_sink_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_last_i,
    output logic byte_ready_o,
    output logic got_o,
    output logic [7:0] got_byte_o,
    output logic got_last_o
);
    integer seed = 32'h51A7;

    initial begin
        byte_ready_o = 1'b1;
        got_o = 1'b0;
        got_byte_o = 8'h00;
        got_last_o = 1'b0;
    end

    // ==========================================================
    // Read side only: never queries while binary mode is on
    always @(negedge clk_i) begin
        byte_ready_o <= !stall_i || (($random(seed) & 3) == 0);
    end

    always @(posedge clk_i) begin
        got_o <= byte_valid_i && byte_ready_o;
        got_byte_o <= byte_i;
        got_last_o <= byte_last_i;
    end
endmodule : byte_sink_model

`default_nettype wire

/* File: verif/measurement_binary_output_framer_test.sv */
// Self-checking bench for the binary output framer.
// Assumes the sink model and the framer package are compiled first.
`timescale 1ns/1ns
`default_nettype none

module measurement_binary_output_framer_test;
    logic clk_i = 1'b0, srst_i = 1'b1, binary_mode_i = 1'b0, start_i = 1'b0;
    logic sample_valid_i = 1'b0, byte_ready_i, stall = 1'b0;
    logic [16:0] block_len_i = 17'h00001;
    bin_framer_pkg::meas_cfg_t cfg_i = '0;
    bin_framer_pkg::sample_t sample_i;
    logic sample_ready_o, byte_valid_o, byte_last_o, busy_o, reject_o;
    logic [7:0] byte_o, got_byte;
    logic [4:0] format_o;
    logic got, got_last, first_s, took;
    logic [79:0] w;
    logic [15:0] st;
    logic [8:0] exp_q[$];
    int err_count = 0, comparisons = 0, left_s = 0;
    integer seed = 32'h8cd0;

    initial forever #50 clk_i = ~clk_i;
    initial sample_i = {$random(seed), $random(seed), 8'($random(seed))};

    measurement_binary_output_framer dut (.clk_i(clk_i), .srst_i(srst_i),
        .binary_mode_i(binary_mode_i), .start_i(start_i), .cfg_i(cfg_i),
        .block_len_i(block_len_i), .sample_valid_i(sample_valid_i), .sample_i(sample_i),
        .sample_ready_o(sample_ready_o), .byte_valid_o(byte_valid_o), .byte_o(byte_o),
        .byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i), .busy_o(busy_o),
        .reject_o(reject_o), .format_o(format_o));

    byte_sink_model sink (.clk_i(clk_i), .stall_i(stall), .byte_valid_i(byte_valid_o),
        .byte_i(byte_o), .byte_last_i(byte_last_o), .byte_ready_o(byte_ready_i),
        .got_o(got), .got_byte_o(got_byte), .got_last_o(got_last));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (e !== g) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Sample source and expected bytes of every sample taken
    always @(posedge clk_i) begin
        if (sample_ready_o === 1'b1 && sample_valid_i) begin
            st = {7'h00, sample_i.totalize_flag_two, sample_i.totalize_flag_one, first_s,
                  sample_i.inhibit, sample_i.interp};
            w = {sample_i.event_count, sample_i.time_count, st};
            left_s--;
            for (int b = 9; b >= 0; b--) exp_q.push_back({left_s == 0 && b == 0, w[b*8 +: 8]});
            first_s = 1'b0;
            took = 1'b1;
        end
    end

    // Valid is held until the sample is taken, then redrawn
    always @(negedge clk_i) begin
        if (!srst_i && (took === 1'b1 || sample_valid_i !== 1'b1)) begin
            sample_valid_i <= ($random(seed) & 3) != 0;
            if (took === 1'b1) begin
                sample_i <= {$random(seed), $random(seed), 8'($random(seed))};
                took = 1'b0;
            end
        end
    end

    // ==========================================================
    // Monitor: oldest note against each byte the sink accepted
    always @(negedge clk_i) begin
        if (got) begin
            if (exp_q.size() == 0) chk("extra byte", 16'hFFFF, {7'h00, got_last, got_byte});
            else chk("byte", {7'h00, exp_q.pop_front()}, {7'h00, got_last, got_byte});
        end
    end

    // Answer code: 2'b10 accepted, 2'b01 refused, 2'b00 ignored
    task automatic frame(input int fn, input int ar, input int ex, input int n,
                         input logic [1:0] ans);
        int len, d;
        len = (n + 1) * 10;
        d = 100000;
        cfg_i = '{bin_framer_pkg::meas_func_t'(fn[3:0]), bin_framer_pkg::arm_mode_t'(ar[1:0]),
                  ex[0]};
        block_len_i = n[16:0];
        if (ans == 2'b10) begin
            first_s = 1'b1;
            left_s = n + 1;
            exp_q.push_back({1'b0, 8'h23});
            exp_q.push_back({1'b0, 8'h36});
            for (int k = 0; k < 6; k++) begin
                exp_q.push_back({1'b0, 8'h30 + 8'((len / d) % 10)});
                d = d / 10;
            end
        end
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        chk("busy reject", {14'h0000, ans}, {14'h0000, busy_o, reject_o});
        if (ans == 2'b10) begin
            chk("format", 16'(fn * 4 + (ar != 0) * 2 + ex), {11'h000, format_o});
            for (int t = 0; t < 3000 && busy_o !== 1'b0; t++) @(negedge clk_i);
            chk("busy end", 16'h0000, {15'h0000, busy_o});
            // Let the monitor drain the byte accepted on the closing edge
            @(negedge clk_i);
            chk("left over", 16'h0000, 16'(exp_q.size()));
        end
        @(negedge clk_i);
    endtask : frame

    initial begin
        repeat (4) @(negedge clk_i);
        srst_i = 1'b0;
        chk("reset out", 16'h0000, {13'h0000, busy_o, reject_o, byte_valid_o});
        binary_mode_i = 1'b1;
        for (int f = 0; f < 5; f++) begin
            for (int a = 0; a < 4; a++) begin
                for (int e = 0; e < 2; e++) frame(f, a, e, 1 + ($random(seed) & 3), 2'b10);
            end
        end
        // Slow reader is ready on one cycle in four at random; output must hold until taken
        stall = 1'b1;
        frame(2, 1, 0, 9, 2'b10);
        stall = 1'b0;
        frame(5, 0, 0, 1, 2'b01);
        frame(6, 2, 1, 1, 2'b01);
        frame(9, 1, 0, 2, 2'b01);
        frame(0, 0, 0, 0, 2'b01);
        frame(1, 0, 0, 99999, 2'b01);
        binary_mode_i = 1'b0;
        frame(0, 0, 0, 1, 2'b00);
        wrap_up();
    end

    initial begin
        #(60000 * 100);
        err_count++;
        wrap_up();
    end
endmodule : measurement_binary_output_framer_test

`default_nettype wire
